// file: sac_top.sv
// Serial transfer and conversion sequencer of a 10-bit converter.
//
// Notes on behaviour
// R1: Select high ignores address and clock; result output floats.
// R2: Host gives 10 to 16 shift clocks per transfer.
// R3: First four clocks load the address; next six time the sampling.
// R4: Address arrives MSB first on four rising edges, picks one of 14 inputs.
// R5: MSB shown at select fall, completion rise, or after 16th fall.
// R6: Nine further result bits leave on the next nine falling edges.
// R7: Conversion starts only at the tenth falling edge.
// R8: Completion flag low at tenth fall, high when result ready.
// R9: Output forced low at tenth fall so extra clocks give zeros.
// R10: Modes 1 and 2 use exactly ten clocks.
// R11: Modes 3 and 5 raise select between cycles, 11 to 16 clocks.
// R12: Modes 4 and 6 keep select low, exactly 16 clocks.
// R13: A ten-clock transfer always finishes before the conversion.
// R14: Select rise floats the output and disables address and clock.
// R15: Continuous select keeps output low until the completion rise.
// R16: Slow modes need the eleventh rise before conversion ends, else resync.
// R17: Eleventh rise within 9.5 us of the tenth fall in slow modes.
// R18: Sampling runs from fourth fall to tenth fall, then holds.
// R19: Self-test inputs are sampled and converted like external ones.
// R20: Multiplexer breaks the old channel before making the new one.
// R21: Select fall resets counters and enables output and inputs.
// R22: Codes 0 to 10 pick external inputs, 11 to 13 self-test inputs.
// R23: Select fall mid-cycle aborts and keeps the previous result.
// R24: Internal controller runs ten decisions, latches result, raises flag.
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_top
#(
    parameter int STEP_CYCLES = `SAC_STEP_CYC
)
(
    // System clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // Serial port from the host.
    input wire logic io_clk,
    input wire logic cs_n,
    input wire logic address,
    // Serial result and completion flag.
    output logic data_out,
    output logic data_out_oe,
    output logic eoc,
    // Analog front end.
    input wire logic cmp_keep,
    output sac_pkg::sac_word_t dac_trial,
    output sac_pkg::sac_chan_t mux_sel,
    output logic sample_en
);
    import sac_pkg::*;

    sac_sar_if conv_if();

    // Link-clock domain.
    logic rise_tgl_q;
    logic rise_tgl_d;
    logic addr_bit_q;
    logic addr_bit_d;
    logic fall_tgl_q;
    logic fall_tgl_d;

    // Synchronisers.
    logic [1:0] cs_s_q;
    logic [1:0] cs_s_d;
    logic cs_prev_q;
    logic cs_prev_d;
    logic [3:0] rise_s_q;
    logic [3:0] rise_s_d;
    logic [3:0] fall_s_q;
    logic [3:0] fall_s_d;
    logic [1:0] addr_s_q;
    logic [1:0] addr_s_d;
    logic [1:0] cmp_s_q;
    logic [1:0] cmp_s_d;

    // Sequencer state.
    sac_state_t state_q;
    sac_state_t state_d;
    sac_cnt_t rise_cnt_q;
    sac_cnt_t rise_cnt_d;
    sac_cnt_t fall_cnt_q;
    sac_cnt_t fall_cnt_d;
    sac_addr_t addr_sh_q;
    sac_addr_t addr_sh_d;
    sac_word_t shreg_q;
    sac_word_t shreg_d;
    logic dout_q;
    logic dout_d;
    logic oe_q;
    logic oe_d;
    logic eoc_q;
    logic eoc_d;
    logic sample_q;
    logic sample_d;
    sac_chan_t mux_q;
    sac_chan_t mux_d;
    logic pend_q;
    logic pend_d;
    sac_chan_t chan_dec;
    logic rise_ev;
    logic fall_ev;
    logic cs_low;
    logic cs_fall;
    logic restart;
    logic start;
    logic abort;

    ////////////////////////////////////////////////////////////////////////////////
    // Link side: select high holds these flops cleared, so the pins are ignored.
    always_comb
    begin
        rise_tgl_d = ~rise_tgl_q;
        addr_bit_d = address;
        fall_tgl_d = ~fall_tgl_q;
    end

    always_ff @(posedge io_clk or posedge cs_n)
    begin
        if (cs_n)
        begin
            rise_tgl_q <= 1'b0; // R1
            addr_bit_q <= 1'b0;
        end
        else
        begin
            rise_tgl_q <= rise_tgl_d;
            addr_bit_q <= addr_bit_d; // R4
        end
    end

    always_ff @(negedge io_clk or posedge cs_n)
    begin
        if (cs_n)
        begin
            fall_tgl_q <= 1'b0; // R14
        end
        else
        begin
            fall_tgl_q <= fall_tgl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Crossings into the system clock; the edge event comes one cycle after
    // the address bit has crossed, so that the bit has settled.
    always_comb
    begin
        cs_s_d = {cs_s_q[0], cs_n};
        cs_prev_d = cs_s_q[1];
        rise_s_d = {rise_s_q[2:0], rise_tgl_q};
        fall_s_d = {fall_s_q[2:0], fall_tgl_q};
        addr_s_d = {addr_s_q[0], addr_bit_q};
        cmp_s_d = {cmp_s_q[0], cmp_keep};
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            cs_s_q <= 2'h3;
            cs_prev_q <= 1'b1;
            rise_s_q <= 4'h0;
            fall_s_q <= 4'h0;
            addr_s_q <= 2'h0;
            cmp_s_q <= 2'h0;
        end
        else
        begin
            cs_s_q <= cs_s_d;
            cs_prev_q <= cs_prev_d;
            rise_s_q <= rise_s_d;
            fall_s_q <= fall_s_d;
            addr_s_q <= addr_s_d;
            cmp_s_q <= cmp_s_d;
        end
    end

    assign cs_low = ~cs_s_q[1];
    assign cs_fall = cs_low & cs_prev_q;
    assign rise_ev = rise_s_q[2] ^ rise_s_q[3];
    assign fall_ev = fall_s_q[2] ^ fall_s_q[3];

    ////////////////////////////////////////////////////////////////////////////////
    // Channel decode; codes 14 and 15 select nothing.
    generate
        for (genvar i = 0; i < `SAC_NUM_CH; i++)
        begin : g_dec
            assign chan_dec[i] = (addr_sh_q == `SAC_ADDR_W'(i)); // R22 R19
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Transfer sequencer.
    always_comb
    begin
        state_d = state_q;
        rise_cnt_d = rise_cnt_q;
        fall_cnt_d = fall_cnt_q;
        addr_sh_d = addr_sh_q;
        shreg_d = shreg_q;
        dout_d = dout_q;
        oe_d = oe_q;
        eoc_d = eoc_q;
        sample_d = sample_q;
        mux_d = mux_q;
        pend_d = 1'b0;
        restart = 1'b0;
        start = 1'b0;
        abort = 1'b0;
        if (pend_q)
        begin
            mux_d = chan_dec; // R20
        end
        if (!cs_low)
        begin
            oe_d = 1'b0; // R1 R14
            dout_d = 1'b0;
            sample_d = 1'b0;
            if (state_q == SAC_CONV)
            begin
                if (conv_if.done)
                begin
                    eoc_d = 1'b1;
                    state_d = SAC_IDLE;
                end
            end
            else
            begin
                state_d = SAC_IDLE;
            end
        end
        else if (cs_fall || state_q == SAC_IDLE)
        begin
            abort = (state_q == SAC_CONV); // R23
            if (abort)
            begin
                eoc_d = 1'b1;
            end
            restart = 1'b1; // R21
        end
        else
        begin
            if (rise_ev && rise_cnt_q != `SAC_CNT_MAX)
            begin
                rise_cnt_d = rise_cnt_q + 1'b1;
                if (rise_cnt_q < `SAC_CNT_ADDR)
                begin
                    addr_sh_d = {addr_sh_q[`SAC_ADDR_W-2:0], addr_s_q[1]}; // R3 R4
                end
            end
            if (fall_ev && fall_cnt_q != `SAC_CNT_MAX)
            begin
                fall_cnt_d = fall_cnt_q + 1'b1;
                if (fall_cnt_d < `SAC_CNT_CONV)
                begin
                    shreg_d = {shreg_q[`SAC_RES_W-2:0], 1'b0};
                    dout_d = shreg_q[`SAC_RES_W-2]; // R6
                end
                if (fall_cnt_d == `SAC_CNT_SAMPLE)
                begin
                    sample_d = 1'b1; // R18
                    if (chan_dec != mux_q)
                    begin
                        mux_d = '0; // R20
                        pend_d = 1'b1;
                    end
                end
                if (fall_cnt_d == `SAC_CNT_CONV && state_q == SAC_SHIFT)
                begin
                    sample_d = 1'b0; // R18
                    dout_d = 1'b0; // R9
                    eoc_d = 1'b0; // R8
                    start = 1'b1; // R7
                    state_d = SAC_CONV;
                end
                if (fall_cnt_d == `SAC_CNT_MAX && state_q == SAC_SLOW)
                begin
                    restart = 1'b1; // R5
                end
            end
            if (state_q == SAC_CONV && conv_if.done)
            begin
                eoc_d = 1'b1; // R8 R24
                // Too few rises when done means fast ten-clock or lost sync.
                if (rise_cnt_q < `SAC_CNT_SLOW || fall_cnt_q == `SAC_CNT_MAX)
                begin
                    restart = 1'b1; // R13 R15 R16
                end
                else
                begin
                    state_d = SAC_SLOW;
                end
            end
        end
        if (restart)
        begin
            state_d = SAC_SHIFT;
            rise_cnt_d = '0;
            fall_cnt_d = '0;
            sample_d = 1'b0;
            oe_d = 1'b1; // R21
            shreg_d = conv_if.result;
            dout_d = conv_if.result[`SAC_RES_W-1]; // R5
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            state_q <= SAC_IDLE;
            rise_cnt_q <= '0;
            fall_cnt_q <= '0;
            addr_sh_q <= '0;
            shreg_q <= `SAC_RESULT_RST;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
            eoc_q <= `SAC_EOC_RST;
            sample_q <= 1'b0;
            mux_q <= '0;
            pend_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            rise_cnt_q <= rise_cnt_d;
            fall_cnt_q <= fall_cnt_d;
            addr_sh_q <= addr_sh_d;
            shreg_q <= shreg_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            eoc_q <= eoc_d;
            sample_q <= sample_d;
            mux_q <= mux_d;
            pend_q <= pend_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Approximation controller.
    assign conv_if.start = start;
    assign conv_if.abort = abort;
    assign conv_if.cmp_keep = cmp_s_q[1];

    sac_sar
    #(
        .STEP_CYCLES(STEP_CYCLES)
    )
    u_sar
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .conv(conv_if.sar)
    );

    assign data_out = dout_q;
    assign data_out_oe = oe_q;
    assign eoc = eoc_q;
    assign dac_trial = conv_if.trial;
    assign mux_sel = mux_q;
    assign sample_en = sample_q;
endmodule // sac_top

// file: sac_consts.svh
// Shared constants for the serial converter control sequencer.
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

`define SAC_ADDR_W 4
`define SAC_RES_W 10
`define SAC_NUM_CH 14
`define SAC_CNT_W 5
`define SAC_CNT_ADDR 5'h04
`define SAC_CNT_SAMPLE 5'h04
`define SAC_CNT_CONV 5'h0A
`define SAC_CNT_SLOW 5'h0B
`define SAC_CNT_MAX 5'h10
`define SAC_SAR_FIRST 10'h200
`define SAC_RESULT_RST 10'h000
`define SAC_EOC_RST 1'b1
`define SAC_STEP_CYC 64

`endif

// file: sac_pkg.sv
// Types for the serial converter control sequencer.
package sac_pkg;
`include "sac_consts.svh"

    typedef logic [`SAC_RES_W-1:0] sac_word_t;
    typedef logic [`SAC_ADDR_W-1:0] sac_addr_t;
    typedef logic [`SAC_CNT_W-1:0] sac_cnt_t;
    typedef logic [`SAC_NUM_CH-1:0] sac_chan_t;

    typedef enum logic [1:0]
    {
        SAC_IDLE = 2'b00,
        SAC_SHIFT = 2'b01,
        SAC_CONV = 2'b10,
        SAC_SLOW = 2'b11
    } sac_state_t;

    typedef enum logic
    {
        SAC_SAR_IDLE = 1'b0,
        SAC_SAR_STEP = 1'b1
    } sac_sar_state_t;
endpackage

// file: sac_sar_if.sv
// Link between the transfer sequencer and the approximation controller.
`timescale 1ns/1ps
interface sac_sar_if;
    import sac_pkg::*;
    logic start;
    logic abort;
    logic cmp_keep;
    logic done;
    sac_word_t trial;
    sac_word_t result;

    modport ctl
    (
        output start,
        output abort,
        output cmp_keep,
        input done,
        input trial,
        input result
    );

    modport sar
    (
        input start,
        input abort,
        input cmp_keep,
        output done,
        output trial,
        output result
    );
endinterface

// file: sac_sar.sv
// Successive-approximation step controller with its result register.
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_sar
#(
    parameter int STEP_CYCLES = `SAC_STEP_CYC
)
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // Sequencer side.
    sac_sar_if.sar conv
);
    import sac_pkg::*;

    localparam int CW = $clog2(STEP_CYCLES + 1);
    localparam logic [CW-1:0] STEP_LAST = CW'(STEP_CYCLES - 1);

    sac_sar_state_t state_q;
    sac_sar_state_t state_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic [3:0] idx_q;
    logic [3:0] idx_d;
    sac_word_t trial_q;
    sac_word_t trial_d;
    sac_word_t result_q;
    sac_word_t result_d;
    logic done_q;
    logic done_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Ten weighted decisions, MSB first, then the result is latched.
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        trial_d = trial_q;
        result_d = result_q;
        done_d = 1'b0;
        if (conv.abort)
        begin
            state_d = SAC_SAR_IDLE;
        end
        else if (conv.start)
        begin
            state_d = SAC_SAR_STEP; // R24
            cnt_d = '0;
            idx_d = 4'h9;
            trial_d = `SAC_SAR_FIRST;
        end
        else if (state_q == SAC_SAR_STEP)
        begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == STEP_LAST)
            begin
                cnt_d = '0;
                if (!conv.cmp_keep)
                begin
                    trial_d[idx_q] = 1'b0;
                end
                if (idx_q == 4'h0)
                begin
                    result_d = trial_d; // R24
                    done_d = 1'b1;
                    state_d = SAC_SAR_IDLE;
                end
                else
                begin
                    trial_d[idx_q - 4'h1] = 1'b1;
                    idx_d = idx_q - 4'h1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            state_q <= SAC_SAR_IDLE;
            cnt_q <= '0;
            idx_q <= 4'h0;
            trial_q <= '0;
            result_q <= `SAC_RESULT_RST;
            done_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            trial_q <= trial_d;
            result_q <= result_d;
            done_q <= done_d;
        end
    end

    assign conv.done = done_q;
    assign conv.trial = trial_q;
    assign conv.result = result_q;
endmodule // sac_sar

// file: sac_top_assertions.sv
// Concurrent checks on the ports of the converter sequencer.
`timescale 1ns/1ps
module sac_top_assertions
import sac_pkg::*;
#(
    parameter int STEP_CYCLES = 64
)
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // Serial port.
    input wire logic io_clk,
    input wire logic cs_n,
    input wire logic address,
    input wire logic data_out,
    input wire logic data_out_oe,
    input wire logic eoc,
    // Analog front end.
    input wire logic cmp_keep,
    input wire sac_pkg::sac_word_t dac_trial,
    input wire sac_pkg::sac_chan_t mux_sel,
    input wire logic sample_en
);
    localparam int CONV_MAX = 10 * STEP_CYCLES + 8;
    int low_q;
    int low_d;
    // Counts the cycles the completion flag has been low.
    always_comb
    begin
        low_d = eoc ? 0 : low_q + 1;
    end
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            low_q <= 0;
        else
            low_q <= low_d;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////
    AST_CS_HIGH_FLOAT: assert property (cs_n [*6] |-> !data_out_oe)
        else $error("Output driven while select high.");
    AST_OE_ON: assert property ($fell(cs_n) |-> ##[2:5] data_out_oe)
        else $error("Output not enabled after select fall.");
    AST_MUX_ONEHOT: assert property ($onehot0(mux_sel))
        else $error("More than one channel closed.");
    AST_MUX_BBM: assert property ((mux_sel != 0) && $changed(mux_sel) |-> $past(mux_sel) == 0)
        else $error("Channel made before break.");
    AST_TENTH_FALL: assert property ($fell(eoc) |-> $fell(sample_en) && !data_out)
        else $error("Tenth fall effects not together.");
    AST_EOC_LOW: assert property ($fell(eoc) |-> !eoc [*8])
        else $error("Completion flag low too briefly.");
    AST_EOC_MAX: assert property (low_q <= CONV_MAX)
        else $error("Conversion runs too long.");
    AST_SAMPLE_EOC: assert property (sample_en |-> eoc)
        else $error("Sampling during conversion.");
    AST_CONT_LOW: assert property (!eoc && $past(!eoc) && !cs_n && !$past(cs_n, 6) |-> !data_out)
        else $error("Output left low level before completion.");
    COV_SEL: cover property ($fell(cs_n));
    COV_DONE: cover property ($rose(eoc));
    COV_SELFTEST: cover property (mux_sel[13]);
    COV_CONT: cover property ($rose(eoc) && !cs_n);
endmodule // sac_top_assertions

bind sac_top sac_top_assertions #(.STEP_CYCLES(STEP_CYCLES)) u_sac_sva
(
    .sys_clk(sys_clk), .reset_n(reset_n), .io_clk(io_clk), .cs_n(cs_n),
    .address(address), .data_out(data_out), .data_out_oe(data_out_oe), .eoc(eoc),
    .cmp_keep(cmp_keep), .dac_trial(dac_trial), .mux_sel(mux_sel), .sample_en(sample_en)
);

// file: sac_host_model.sv
// Host serial port model that runs transfers and captures returned bits.
`timescale 1ns/1ps
module sac_host_model
(
    // Serial port toward the converter.
    output logic io_clk,
    output logic cs_n,
    output logic address,
    // Returned result line.
    input wire logic data_in
);
    initial
    begin
        io_clk = 1'b0;
        cs_n = 1'b1;
        address = 1'b0;
    end
    // The shift clock stands still outside transfers; half period is 80 ns.
    task automatic xfer(input logic [3:0] ad, input int n, input bit keep_low,
        output logic [15:0] cap);
        int k;
        cap = 16'h0000;
        if (cs_n)
        begin
            #100;
            cs_n = 1'b0;
            #100;
        end
        for (k = 0; k < n; k++)
        begin
            address = (k < 4) ? ad[3 - k] : ~address;
            #80;
            cap = {cap[14:0], data_in};
            io_clk = 1'b1;
            #80;
            io_clk = 1'b0;
        end
        #80;
        if (!keep_low)
            cs_n = 1'b1;
    endtask
endmodule // sac_host_model

// file: serial_adc_control_sequencer_tb.sv
// Self-checking bench for the serial converter control sequencer.
`timescale 1ns/1ps
module serial_adc_control_sequencer_tb;
    import sac_pkg::*;
    localparam int STEP = 8;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cmp_keep = 1'b0;
    logic io_clk, cs_n, address, data_out, data_out_oe, eoc, sample_en, dout_line;
    sac_word_t dac_trial;
    sac_chan_t mux_sel;
    sac_word_t vin [0:15];
    sac_word_t vnow = 10'h000;
    sac_word_t prev = 10'h000;
    sac_word_t old;
    logic [15:0] cap;
    logic [3:0] a;
    int n_errors = 0;
    int compares = 0;
    int i;
    int n;
    always #4 sys_clk = ~sys_clk;
    // A released result line shows the inverse level, never a held value.
    assign dout_line = data_out_oe ? data_out : ~data_out;
    // Comparator keeps a trial bit while the trial does not exceed the input.
    always @(posedge sys_clk) cmp_keep <= #1 (dac_trial <= vnow);
    sac_top #(.STEP_CYCLES(STEP)) u_dut
    (
        .sys_clk(sys_clk), .reset_n(reset_n), .io_clk(io_clk), .cs_n(cs_n),
        .address(address), .data_out(data_out), .data_out_oe(data_out_oe), .eoc(eoc),
        .cmp_keep(cmp_keep), .dac_trial(dac_trial), .mux_sel(mux_sel), .sample_en(sample_en)
    );
    sac_host_model u_host
    (
        .io_clk(io_clk), .cs_n(cs_n), .address(address), .data_in(dout_line)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("Compares %0d, errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_eoc;
        int t;
        for (t = 0; t < 2000 && eoc !== 1'b1; t++)
        begin
            @(posedge sys_clk);
            #1;
        end
        if (eoc !== 1'b1)
        begin
            n_errors++;
            $display("[FAIL] %0t completion flag never rose", $time);
            print_verdict();
        end
    endtask
    // Ten result bits MSB first, then a zero for every clock beyond ten.
    function automatic logic [15:0] exp_word(input sac_word_t r, input int nc);
        return {6'h00, r} << (nc - 10);
    endfunction
    // One closed switch for a valid channel code.
    function automatic sac_chan_t exp_chan(input logic [3:0] ad);
        return 14'h0001 << ad;
    endfunction
    // One transfer: the returned word is the previous result, then zeros.
    task automatic xact(input logic [3:0] ad, input int nc, input bit keep);
        vnow = vin[ad];
        u_host.xfer(ad, nc, keep, cap);
        chk_word(cap, exp_word(prev, nc));
        chk_word({2'b00, mux_sel}, {2'b00, exp_chan(ad)});
        prev = vin[ad];
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'hEEA5));
        for (i = 0; i < 16; i++)
            vin[i] = 10'($urandom);
        vin[11] = 10'h200;
        vin[12] = 10'h000;
        vin[13] = 10'h3FF;
        repeat (6) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        chk_bit(eoc, 1'b1);
        chk_bit(data_out_oe, 1'b0);
        chk_word({2'b00, mux_sel}, 16'h0000);
        for (i = 0; i < 8; i++)
        begin
            a = (i < 3) ? 4'hB + 4'(i) : 4'($urandom_range(13, 0));
            xact(a, 10, 1'b0);
            wait_eoc();
            chk_bit(data_out_oe, 1'b0);
        end
        for (i = 0; i < 6; i++)
        begin
            n = (i == 0) ? 11 : (i == 1) ? 16 : $urandom_range(16, 11);
            xact(4'($urandom_range(13, 0)), n, 1'b0);
            wait_eoc();
        end
        old = prev;
        xact(4'h3, 10, 1'b0);
        prev = old;
        xact(4'h7, 10, 1'b0);
        wait_eoc();
        u_host.xfer(4'h5, 6, 1'b0, cap);
        chk_word(cap, {6'h00, prev >> 4});
        repeat (100) @(posedge sys_clk);
        #1;
        chk_bit(eoc, 1'b1);
        for (i = 0; i < 3; i++)
        begin
            xact(4'($urandom_range(13, 0)), 10, 1'b1);
            wait_eoc();
            chk_bit(data_out, prev[9]);
        end
        for (i = 0; i < 4; i++)
        begin
            xact(4'($urandom_range(13, 0)), 16, i < 3);
            wait_eoc();
            chk_bit(dout_line, prev[9]);
        end
        repeat (8) @(posedge sys_clk);
        #1;
        chk_bit(data_out_oe, 1'b0);
        print_verdict();
    end
endmodule // serial_adc_control_sequencer_tb
